// ==== hw/sidx_pkg.sv ====
// constants, encodings and register map of the stepper indexer control block
package sidx_pkg;

    // indexer position and step table
    localparam int         POS_W     = 5;
    localparam logic [4:0] POS_HOME  = 5'h04;
    localparam logic [4:0] QTR_TURN  = 5'h08;
    localparam logic [7:0] CUR_HOME  = 8'h47;
    localparam logic [7:0] MAG_TBL [0:8] = '{8'h64, 8'h62, 8'h5c, 8'h53, 8'h47, 8'h38, 8'h26, 8'h14, 8'h00};

    // microstep select codes and their table increments
    localparam logic [1:0] MSEL_FULL    = 2'h0;
    localparam logic [1:0] MSEL_HALF    = 2'h1;
    localparam logic [1:0] MSEL_QUARTER = 2'h2;
    localparam logic [1:0] MSEL_EIGHTH  = 2'h3;
    localparam logic [4:0] INC_FULL     = 5'h08;
    localparam logic [4:0] INC_HALF     = 5'h04;
    localparam logic [4:0] INC_QUARTER  = 5'h02;
    localparam logic [4:0] INC_EIGHTH   = 5'h01;

    // synchronised pin vector
    localparam int         PIN_N    = 5;
    localparam int         PIN_STEP = 0;
    localparam int         PIN_DIR  = 1;
    localparam int         PIN_CLR  = 2;
    localparam int         PIN_EN   = 3;
    localparam int         PIN_SLP  = 4;
    localparam logic [4:0] PIN_RST  = 5'h00;

    // register byte addresses
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CMD    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_POS    = 4'hc;

    // control register fields and reset values
    localparam int         CTRL_OVR_BIT  = 0;
    localparam int         CTRL_MODE_LSB = 1;
    localparam logic       CTRL_OVR_RST  = 1'b0;
    localparam logic [1:0] CTRL_MODE_RST = 2'h0;

    // step command fields
    localparam int CMD_STEP_BIT = 0;
    localparam int CMD_DIR_BIT  = 1;

    // status fields
    localparam int ST_HOME  = 0;
    localparam int ST_BR_LSB = 1;
    localparam int ST_OC_LSB = 3;
    localparam int ST_OT    = 5;
    localparam int ST_UV    = 6;
    localparam int ST_MODE_LSB = 7;
    localparam int ST_CLR   = 9;

    // position register fields
    localparam int POS_CUR_A_LSB = 8;
    localparam int POS_CUR_B_LSB = 16;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_RUN     = 2'h0,
        MODE_SLEEP   = 2'h1,
        MODE_LOCKOUT = 2'h3
    } sidx_mode_t;

    typedef enum logic [2:0] {
        SEL_CTRL, SEL_CMD, SEL_STATUS, SEL_POS, SEL_NONE
    } sidx_sel_t;

endpackage

// ==== hw/sidx_step_rom.sv ====
// winding current table: position in, registered signed percentages out
`timescale 1ns/1ns
`default_nettype none
module sidx_step_rom (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // table port
    sidx_tbl_if.rom   tbl
);

    // cosine in percent of full scale, built from one quarter of the circle
    function automatic logic [7:0] cos_pct(input logic [4:0] k);
        logic [7:0] m;
        logic [3:0] r;
        logic [3:0] rr;
        r  = {1'b0, k[2:0]};
        rr = 4'(4'h8 - r);
        m  = 8'h00;
        case (k[4:3])
            2'h0: m = sidx_pkg::MAG_TBL[r];
            2'h1: m = 8'(-sidx_pkg::MAG_TBL[rr]);
            2'h2: m = 8'(-sidx_pkg::MAG_TBL[r]);
            2'h3: m = sidx_pkg::MAG_TBL[rr];
        endcase
        return m;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tbl.cur_a <= sidx_pkg::CUR_HOME;
            tbl.cur_b <= sidx_pkg::CUR_HOME;
        end else begin
            tbl.cur_a <= cos_pct(tbl.pos);
            // winding b lags a by a quarter turn
            tbl.cur_b <= cos_pct(5'(tbl.pos - sidx_pkg::QTR_TURN));
        end
    end

endmodule
`default_nettype wire

// ==== hw/sidx_tbl_if.sv ====
// link between the indexer control and its winding current table
`timescale 1ns/1ns
`default_nettype none
interface sidx_tbl_if;
    logic [4:0] pos;
    logic [7:0] cur_a;
    logic [7:0] cur_b;
    modport rom (input pos, output cur_a, output cur_b);
    modport ctl (output pos, input cur_a, input cur_b);
endinterface
`default_nettype wire

// ==== hw/sidx_top.sv ====
// stepper indexer control and fault gating with an axi4-lite register slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module sidx_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // host control pins
    input  wire logic        step_in,
    input  wire logic        dir_in,
    input  wire logic        indexer_clear_l,
    input  wire logic        bridge_drive_on_l,
    input  wire logic        low_power_request_l,
    input  wire logic        microstep_sel_hi,
    input  wire logic        microstep_sel_lo,
    // protection flags
    input  wire logic [1:0]  overcurrent_trip,
    input  wire logic        overtemp_trip,
    input  wire logic        supply_low_lockout,
    // drive outputs
    output logic             origin_flag_l,
    output logic [1:0]       bridge_on,
    output logic             charge_pump_on,
    output logic [7:0]       winding_a_pct,
    output logic [7:0]       winding_b_pct
);

    sidx_tbl_if tbl ();

    logic [sidx_pkg::PIN_N-1:0] pin_raw;
    logic [sidx_pkg::PIN_N-1:0] sync1_reg;
    logic [sidx_pkg::PIN_N-1:0] sync2_reg;
    logic                       step_prev_reg;
    logic                       en_prev_reg;
    logic [4:0]                 pos_reg;
    logic [1:0]                 oc_reg;
    sidx_pkg::sidx_mode_t       mode_reg;
    logic                       ctrl_ovr_reg;
    logic [1:0]                 ctrl_mode_reg;
    logic                       soft_step_reg;
    logic                       soft_dir_reg;
    logic                       aw_full_reg;
    logic                       w_full_reg;
    logic [31:0]                awaddr_reg;
    logic [31:0]                wdata_reg;
    logic [3:0]                 wstrb_reg;
    logic [31:0]                rd_word;
    logic                       clear_a;
    logic                       en_a;
    logic                       sleep_a;
    logic                       step_rise;
    logic                       en_fall;
    logic                       step_go;
    logic                       step_fwd;
    logic                       wr_go;
    logic [1:0]                 msel;
    logic [4:0]                 inc;
    sidx_pkg::sidx_sel_t        wr_sel;
    sidx_pkg::sidx_sel_t        rd_sel;

    // word decode shared by the read and write paths
    function automatic sidx_pkg::sidx_sel_t reg_sel(input logic [31:0] a);
        sidx_pkg::sidx_sel_t s;
        s = sidx_pkg::SEL_NONE;
        if (a[31:4] == 28'h0000000) begin
            case (a[3:0])
                sidx_pkg::REG_CTRL:   s = sidx_pkg::SEL_CTRL;
                sidx_pkg::REG_CMD:    s = sidx_pkg::SEL_CMD;
                sidx_pkg::REG_STATUS: s = sidx_pkg::SEL_STATUS;
                sidx_pkg::REG_POS:    s = sidx_pkg::SEL_POS;
                default:              s = sidx_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction

    assign pin_raw[sidx_pkg::PIN_STEP] = step_in;
    assign pin_raw[sidx_pkg::PIN_DIR]  = dir_in;
    assign pin_raw[sidx_pkg::PIN_CLR]  = indexer_clear_l;
    assign pin_raw[sidx_pkg::PIN_EN]   = bridge_drive_on_l;
    assign pin_raw[sidx_pkg::PIN_SLP]  = low_power_request_l;

    // two flops per pin; only the second stage is looked at
    for (genvar g = 0; g < sidx_pkg::PIN_N; g++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1_reg[g] <= sidx_pkg::PIN_RST[g];
                sync2_reg[g] <= sidx_pkg::PIN_RST[g];
            end else begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    assign clear_a = ~sync2_reg[sidx_pkg::PIN_CLR];
    assign en_a    = ~sync2_reg[sidx_pkg::PIN_EN];
    assign sleep_a = ~sync2_reg[sidx_pkg::PIN_SLP];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_prev_reg <= 1'b0;
            en_prev_reg   <= 1'b0;
        end else begin
            step_prev_reg <= sync2_reg[sidx_pkg::PIN_STEP];
            en_prev_reg   <= en_a;
        end
    end

    // sleep masks every event so nothing stale is acted on at wake-up
    assign step_rise = sync2_reg[sidx_pkg::PIN_STEP] & ~step_prev_reg & ~sleep_a;
    assign en_fall   = en_a & ~en_prev_reg & ~sleep_a;
    assign step_go   = step_rise | soft_step_reg;
    assign step_fwd  = step_rise ? sync2_reg[sidx_pkg::PIN_DIR] : soft_dir_reg;
    assign msel      = ctrl_ovr_reg ? ctrl_mode_reg : {microstep_sel_hi, microstep_sel_lo};

    always_comb begin
        unique case (msel)
            sidx_pkg::MSEL_FULL:    inc = sidx_pkg::INC_FULL;
            sidx_pkg::MSEL_HALF:    inc = sidx_pkg::INC_HALF;
            sidx_pkg::MSEL_QUARTER: inc = sidx_pkg::INC_QUARTER;
            sidx_pkg::MSEL_EIGHTH:  inc = sidx_pkg::INC_EIGHTH;
        endcase
    end

    // lockout beats sleep, sleep freezes, clear and overtemperature send home
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_reg <= sidx_pkg::POS_HOME;
        end else if (supply_low_lockout) begin
            pos_reg <= sidx_pkg::POS_HOME;
        end else if (sleep_a) begin
            pos_reg <= pos_reg;
        end else if (clear_a || overtemp_trip) begin
            pos_reg <= sidx_pkg::POS_HOME;
        end else if (step_go) begin
            pos_reg <= step_fwd ? 5'(pos_reg + inc) : 5'(pos_reg - inc);
        end
    end

    assign tbl.pos = pos_reg;

    sidx_step_rom u_rom (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tbl     (tbl)
    );

    assign winding_a_pct = tbl.cur_a;
    assign winding_b_pct = tbl.cur_b;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            origin_flag_l <= 1'b0;
        end else begin
            origin_flag_l <= (pos_reg != sidx_pkg::POS_HOME);
        end
    end

    // per bridge: outside sleep a trip wins over a same-cycle release
    for (genvar b = 0; b < 2; b++) begin : g_bridge
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                oc_reg[b] <= 1'b0;
            end else if (overcurrent_trip[b] && !sleep_a) begin
                oc_reg[b] <= 1'b1;
            end else if (en_fall || supply_low_lockout) begin
                oc_reg[b] <= 1'b0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                bridge_on[b] <= 1'b0;
            end else begin
                bridge_on[b] <= ~supply_low_lockout & ~sleep_a & en_a & ~clear_a
                                & ~overtemp_trip & ~oc_reg[b] & ~overcurrent_trip[b];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            charge_pump_on <= 1'b0;
        end else begin
            charge_pump_on <= ~supply_low_lockout & ~sleep_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= sidx_pkg::MODE_RUN;
        end else if (supply_low_lockout) begin
            mode_reg <= sidx_pkg::MODE_LOCKOUT;
        end else if (sleep_a) begin
            mode_reg <= sidx_pkg::MODE_SLEEP;
        end else begin
            mode_reg <= sidx_pkg::MODE_RUN;
        end
    end

    // write channel: address and data taken in either order, then one response
    assign wr_go  = aw_full_reg & w_full_reg & ~bvalid;
    assign wr_sel = reg_sel(awaddr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b0;
            aw_full_reg <= 1'b0;
            awaddr_reg  <= 32'h00000000;
        end else if (awvalid && awready) begin
            awready     <= 1'b0;
            aw_full_reg <= 1'b1;
            awaddr_reg  <= awaddr;
        end else if (bvalid && bready) begin
            aw_full_reg <= 1'b0;
        end else if (!aw_full_reg && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready     <= 1'b0;
            w_full_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end else if (wvalid && wready) begin
            wready     <= 1'b0;
            w_full_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
        end else if (bvalid && bready) begin
            w_full_reg <= 1'b0;
        end else if (!w_full_reg && !bvalid) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= sidx_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= (wr_sel == sidx_pkg::SEL_NONE) ? sidx_pkg::RESP_SLVERR : sidx_pkg::RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ovr_reg  <= sidx_pkg::CTRL_OVR_RST;
            ctrl_mode_reg <= sidx_pkg::CTRL_MODE_RST;
        end else if (wr_go && wr_sel == sidx_pkg::SEL_CTRL && wstrb_reg[0]) begin
            ctrl_ovr_reg  <= wdata_reg[sidx_pkg::CTRL_OVR_BIT];
            ctrl_mode_reg <= wdata_reg[sidx_pkg::CTRL_MODE_LSB +: 2];
        end
    end

    // software step is a one-cycle pulse; it obeys the same gating as the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_step_reg <= 1'b0;
            soft_dir_reg  <= 1'b0;
        end else begin
            soft_step_reg <= wr_go && wr_sel == sidx_pkg::SEL_CMD && wstrb_reg[0]
                             && wdata_reg[sidx_pkg::CMD_STEP_BIT] && !sleep_a;
            if (wr_go && wr_sel == sidx_pkg::SEL_CMD && wstrb_reg[0]) begin
                soft_dir_reg <= wdata_reg[sidx_pkg::CMD_DIR_BIT];
            end
        end
    end

    // read channel
    assign rd_sel = reg_sel(araddr);

    always_comb begin
        rd_word = 32'h00000000;
        unique case (rd_sel)
            sidx_pkg::SEL_CTRL: begin
                rd_word[sidx_pkg::CTRL_OVR_BIT]       = ctrl_ovr_reg;
                rd_word[sidx_pkg::CTRL_MODE_LSB +: 2] = ctrl_mode_reg;
            end
            sidx_pkg::SEL_STATUS: begin
                rd_word[sidx_pkg::ST_HOME]          = ~origin_flag_l;
                rd_word[sidx_pkg::ST_BR_LSB +: 2]   = bridge_on;
                rd_word[sidx_pkg::ST_OC_LSB +: 2]   = oc_reg;
                rd_word[sidx_pkg::ST_OT]            = overtemp_trip;
                rd_word[sidx_pkg::ST_UV]            = supply_low_lockout;
                rd_word[sidx_pkg::ST_MODE_LSB +: 2] = mode_reg;
                rd_word[sidx_pkg::ST_CLR]           = clear_a;
            end
            sidx_pkg::SEL_POS: begin
                rd_word[4:0]                          = pos_reg;
                rd_word[sidx_pkg::POS_CUR_A_LSB +: 8] = tbl.cur_a;
                rd_word[sidx_pkg::POS_CUR_B_LSB +: 8] = tbl.cur_b;
            end
            sidx_pkg::SEL_CMD, sidx_pkg::SEL_NONE: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= sidx_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= (rd_sel == sidx_pkg::SEL_NONE) ? sidx_pkg::RESP_SLVERR : sidx_pkg::RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ==== tb/sidx_host_model.sv ====
// host controller model driving step, direction and enable pins
`timescale 1ns/1ns
`default_nettype none
module sidx_host_model (
    // clock
    input wire logic aclk,
    // pins
    output var logic step_in,
    output var logic dir_in,
    output var logic bridge_drive_on_l
);
    initial begin
        step_in = 1'b0;
        dir_in = 1'b1;
        bridge_drive_on_l = 1'b0;
    end
    // three cycles each way clears the two-flop synchroniser
    task automatic step(input logic d);
        dir_in <= d;
        @(posedge aclk);
        step_in <= 1'b1;
        repeat (3) @(posedge aclk);
        step_in <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic drive_en(input logic v);
        bridge_drive_on_l <= v;
        @(posedge aclk);
    endtask
    task automatic recover;
        drive_en(1'b1);
        repeat (4) @(posedge aclk);
        drive_en(1'b0);
    endtask
endmodule
`default_nettype wire

// ==== tb/sidx_monitor.sv ====
// assertion checker on the stepper indexer control ports
`timescale 1ns/1ns
`default_nettype none
module sidx_monitor (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // pins and flags
    input wire logic       bridge_drive_on_l,
    input wire logic       indexer_clear_l,
    input wire logic       low_power_request_l,
    input wire logic [1:0] overcurrent_trip,
    input wire logic       overtemp_trip,
    input wire logic       supply_low_lockout,
    // drive outputs
    input wire logic       origin_flag_l,
    input wire logic [1:0] bridge_on,
    input wire logic       charge_pump_on,
    input wire logic [7:0] winding_a_pct,
    input wire logic [7:0] winding_b_pct
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // enable pin held still around the trip, so no release can be in flight
    sequence oc_trip_quiet_en;
        overcurrent_trip[0] && bridge_drive_on_l == $past(bridge_drive_on_l)
            && bridge_drive_on_l == $past(bridge_drive_on_l, 2);
    endsequence
    sequence oc_gone;
        (!overcurrent_trip[0] && !supply_low_lockout && $stable(bridge_drive_on_l))[*4];
    endsequence
    a_uv_all_off: assert property (supply_low_lockout |=> bridge_on == 2'h0 && !charge_pump_on)
        else $error("bridge or pump on under lockout");
    a_uv_home: assert property (supply_low_lockout[*2] |=> !origin_flag_l)
        else $error("not home under lockout");
    a_ot_bridges_off: assert property (overtemp_trip |=> bridge_on == 2'h0)
        else $error("bridge on under overtemperature");
    a_ot_home: assert property (overtemp_trip ##1 overtemp_trip |=> !origin_flag_l)
        else $error("not home under overtemperature");
    a_oc_cut: assert property (overcurrent_trip[0] |=> !bridge_on[0])
        else $error("bridge a on during overcurrent");
    a_oc_latched: assert property (oc_trip_quiet_en ##1 oc_gone |-> !bridge_on[0])
        else $error("overcurrent latch released early");
    a_sleep_off: assert property (!low_power_request_l[*3] |=> bridge_on == 2'h0 && !charge_pump_on)
        else $error("bridge or pump on while asleep");
    a_disable_off: assert property (bridge_drive_on_l[*3] |=> bridge_on == 2'h0)
        else $error("bridge on while disabled");
    a_clear_home: assert property (!indexer_clear_l[*4] |=> !origin_flag_l && bridge_on == 2'h0)
        else $error("clear did not send home or cut bridges");
    a_origin_match: assert property (origin_flag_l == !(winding_a_pct == 8'h47 && winding_b_pct == 8'h47))
        else $error("origin flag disagrees with table entry");
endmodule
bind sidx_top sidx_monitor u_sidx_monitor (
    .aclk(aclk), .aresetn(aresetn), .bridge_drive_on_l(bridge_drive_on_l), .indexer_clear_l(indexer_clear_l),
    .low_power_request_l(low_power_request_l), .overcurrent_trip(overcurrent_trip),
    .overtemp_trip(overtemp_trip), .supply_low_lockout(supply_low_lockout), .origin_flag_l(origin_flag_l),
    .bridge_on(bridge_on), .charge_pump_on(charge_pump_on), .winding_a_pct(winding_a_pct),
    .winding_b_pct(winding_b_pct)
);
`default_nettype wire

// ==== tb/sidx_top_tb.sv ====
// self-checking bench for the stepper indexer control block
`timescale 1ns/1ns
`default_nettype none
module sidx_top_tb;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, step_in, dir_in, indexer_clear_l;
    logic        bridge_drive_on_l, low_power_request_l, microstep_sel_hi, microstep_sel_lo;
    logic        overtemp_trip, supply_low_lockout, origin_flag_l, charge_pump_on;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_data;
    logic [1:0]  bresp, rresp, rd_resp, wr_resp, overcurrent_trip, bridge_on;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot;
    logic [7:0]  winding_a_pct, winding_b_pct;
    int          err_total, checks_done;
    sidx_top u_sidx_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .step_in(step_in), .dir_in(dir_in),
        .indexer_clear_l(indexer_clear_l), .bridge_drive_on_l(bridge_drive_on_l),
        .low_power_request_l(low_power_request_l), .microstep_sel_hi(microstep_sel_hi),
        .microstep_sel_lo(microstep_sel_lo), .overcurrent_trip(overcurrent_trip), .overtemp_trip(overtemp_trip),
        .supply_low_lockout(supply_low_lockout), .origin_flag_l(origin_flag_l), .bridge_on(bridge_on),
        .charge_pump_on(charge_pump_on), .winding_a_pct(winding_a_pct), .winding_b_pct(winding_b_pct));
    sidx_host_model u_sidx_host_model (.aclk(aclk), .step_in(step_in), .dir_in(dir_in),
        .bridge_drive_on_l(bridge_drive_on_l));
    always #50 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        wr_resp = bresp;
        // one idle edge so a following call never re-raises bready in this time step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge aclk);
    endtask
    task automatic pos_is(input logic [4:0] e);
        rd({28'h0, sidx_pkg::REG_POS});
        chk({27'h0, rd_data[4:0]}, {27'h0, e});
    endtask
    task automatic br_is(input logic [1:0] e);
        chk({30'h0, bridge_on}, {30'h0, e});
    endtask
    initial begin
        wt(5000);
        err_total++;
        test_done();
    end
    initial begin
        aclk = 0; aresetn = 0; awaddr = 0; awvalid = 0; wdata = 0; wvalid = 0; bready = 0;
        araddr = 0; arvalid = 0; rready = 0; indexer_clear_l = 1; low_power_request_l = 1;
        microstep_sel_hi = 0; microstep_sel_lo = 0; overcurrent_trip = 0; overtemp_trip = 0;
        supply_low_lockout = 0; err_total = 0; checks_done = 0;
        wstrb = 4'hf; awprot = 3'h0; arprot = 3'h0; wr_resp = 2'h0;
        wt(4);
        aresetn <= 1'b1;
        wt(6);
        chk({31'h0, origin_flag_l}, 32'h0);
        chk({winding_b_pct, winding_a_pct}, {2{sidx_pkg::CUR_HOME}});
        br_is(2'h3);
        rd(32'h0); chk(rd_data, 32'h0);
        wr(32'h0, 32'h5); chk({30'h0, wr_resp}, {30'h0, sidx_pkg::RESP_OKAY});
        rd(32'h0); chk(rd_data, 32'h5);
        u_sidx_host_model.step(1'b1); pos_is(5'h06);
        u_sidx_host_model.step(1'b0); pos_is(5'h04);
        wr(32'h0, 32'h0); rd(32'h10); chk({30'h0, rd_resp}, {30'h0, sidx_pkg::RESP_SLVERR});
        wr(32'h10, 32'h1); chk({30'h0, wr_resp}, {30'h0, sidx_pkg::RESP_SLVERR});
        // byte 0 not strobed: the control word must stay as it was
        wstrb <= 4'he; awprot <= 3'h2; arprot <= 3'h2;
        wr(32'h0, 32'h1); rd(32'h0); chk(rd_data, 32'h0);
        wstrb <= 4'hf;
        wr(32'h4, 32'h3); pos_is(5'h0c);
        wr(32'h4, 32'h1); pos_is(5'h04);
        for (int m = 0; m < 4; m++) begin
            {microstep_sel_hi, microstep_sel_lo} <= 2'(m);
            u_sidx_host_model.step(1'b1); pos_is(5'(4 + (8 >> m)));
            u_sidx_host_model.step(1'b0); pos_is(5'h04);
        end
        {microstep_sel_hi, microstep_sel_lo} <= 2'h0;
        u_sidx_host_model.drive_en(1'b1); wt(5); br_is(2'h0);
        u_sidx_host_model.step(1'b1); pos_is(5'h0c);
        chk({16'h0, winding_b_pct, winding_a_pct}, 32'h000047b9);
        u_sidx_host_model.drive_en(1'b0);
        indexer_clear_l <= 1'b0; wt(5); br_is(2'h0);
        chk({31'h0, origin_flag_l}, 32'h0);
        u_sidx_host_model.step(1'b1); indexer_clear_l <= 1'b1; wt(5); pos_is(5'h04);
        br_is(2'h3);
        // both self-clearing faults: trip from an off-home entry
        for (int f = 0; f < 2; f++) begin
            u_sidx_host_model.step(1'b1);
            if (f == 0) overtemp_trip <= 1'b1;
            else supply_low_lockout <= 1'b1;
            wt(4); br_is(2'h0);
            chk({31'h0, origin_flag_l}, 32'h0);
            chk({31'h0, charge_pump_on}, 32'(f == 0));
            overtemp_trip <= 1'b0; supply_low_lockout <= 1'b0; wt(5); br_is(2'h3);
        end
        u_sidx_host_model.step(1'b1); low_power_request_l <= 1'b0; wt(5);
        chk({29'h0, charge_pump_on, bridge_on}, 32'h0);
        u_sidx_host_model.step(1'b1); low_power_request_l <= 1'b1; wt(5); pos_is(5'h0c);
        br_is(2'h3);
        for (int b = 0; b < 2; b++) begin
            overcurrent_trip <= 2'(1 << b); wt(1); overcurrent_trip <= 2'h0; wt(10);
            br_is(2'h3 ^ 2'(1 << b));
            u_sidx_host_model.recover(); wt(5); br_is(2'h3);
        end
        test_done();
    end
endmodule
`default_nettype wire
